// ---- rtl/port_ctrl_pkg.sv ----
`default_nettype none

package port_ctrl_pkg;

	localparam int          NUM_PORTS     = 5;
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 8;
	localparam int          VID_W         = 12;
	localparam int          PRIO_W        = 2;

	// per-port control byte addresses
	localparam logic [7:0]  PORT1_CTRL_ADDR = 8'h10;
	localparam logic [7:0]  PORT2_CTRL_ADDR = 8'h20;
	localparam logic [7:0]  PORT3_CTRL_ADDR = 8'h30;
	localparam logic [7:0]  PORT4_CTRL_ADDR = 8'h40;
	localparam logic [7:0]  PORT5_CTRL_ADDR = 8'h50;

	// field positions
	localparam int          STORM_EN_BIT   = 7;
	localparam int          DSCP_EN_BIT    = 6;
	localparam int          PCP_EN_BIT     = 5;
	localparam int          PORT_PRIO_HI   = 4;
	localparam int          PORT_PRIO_LO   = 3;
	localparam int          TAG_INSERT_BIT = 2;
	localparam int          TAG_REMOVE_BIT = 1;
	localparam int          SPLIT_LO_BIT   = 0;

	localparam logic [7:0]  CTRL_RESET     = 8'h00;

	// combined queue split code {companion bit, low bit}
	localparam logic [1:0]  SPLIT_SINGLE   = 2'h0;
	localparam logic [1:0]  SPLIT_TWO      = 2'h1;
	localparam logic [1:0]  SPLIT_FOUR     = 2'h2;
	localparam logic [1:0]  SPLIT_RSVD     = 2'h3;

	localparam logic [2:0]  NO_PORT        = 3'h7;

endpackage : port_ctrl_pkg

`default_nettype wire

// ---- rtl/port_ingress_priority_tag_control.sv ----
`timescale 1ns/1ns
`default_nettype none

module port_ingress_priority_tag_control
	import port_ctrl_pkg::*;
(
	input  wire logic                       ref_clk_in,
	input  wire logic                       sys_rst_in,
	input  wire logic                       ref_clk_en_in,
	input  wire logic                       reg_wr_en_in,
	input  wire logic                       reg_rd_en_in,
	input  wire logic [ADDR_W-1:0]          reg_addr_in,
	input  wire logic [DATA_W-1:0]          reg_wdata_in,
	input  wire logic [NUM_PORTS-1:0]       split_hi_in,
	input  wire logic [NUM_PORTS*VID_W-1:0] port_default_vlan_id_in,
	input  wire logic                       ingress_valid_in,
	input  wire logic [2:0]                 ingress_port_in,
	input  wire logic                       dscp_valid_in,
	input  wire logic [PRIO_W-1:0]          dscp_prio_in,
	input  wire logic                       pcp_valid_in,
	input  wire logic [PRIO_W-1:0]          pcp_prio_in,
	input  wire logic                       egress_valid_in,
	input  wire logic [2:0]                 egress_port_in,
	input  wire logic [2:0]                 egress_src_port_in,
	input  wire logic                       egress_arrived_tagged_in,
	output logic      [DATA_W-1:0]          reg_rdata_out,
	output logic      [NUM_PORTS-1:0]       storm_protect_en_out,
	output logic                            class_valid_out,
	output logic      [PRIO_W-1:0]          class_prio_out,
	output logic      [PRIO_W-1:0]          class_queue_out,
	output logic                            egress_valid_out,
	output logic                            egress_add_tag_out,
	output logic                            egress_strip_tag_out,
	output logic      [VID_W-1:0]           egress_vid_out
);

	logic [DATA_W-1:0] ctrl [NUM_PORTS];
	logic [2:0]        sel;
	logic [DATA_W-1:0] ictl;
	logic [DATA_W-1:0] ectl;
	logic [PRIO_W-1:0] next_prio;
	logic [PRIO_W-1:0] next_queue;
	logic [1:0]        split_code;
	logic              use_dscp;
	logic              use_pcp;

	// address to port index, NO_PORT when unmapped
	function automatic logic [2:0] port_of_addr(input logic [ADDR_W-1:0] a);
		case (a)
			PORT1_CTRL_ADDR: port_of_addr = 3'h0;
			PORT2_CTRL_ADDR: port_of_addr = 3'h1;
			PORT3_CTRL_ADDR: port_of_addr = 3'h2;
			PORT4_CTRL_ADDR: port_of_addr = 3'h3;
			PORT5_CTRL_ADDR: port_of_addr = 3'h4;
			default:         port_of_addr = NO_PORT;
		endcase
	endfunction : port_of_addr

	// control byte of a port, zero for an out of range index
	function automatic logic [DATA_W-1:0] ctrl_of(input logic [2:0] p,
			input logic [DATA_W-1:0] c0, input logic [DATA_W-1:0] c1,
			input logic [DATA_W-1:0] c2, input logic [DATA_W-1:0] c3,
			input logic [DATA_W-1:0] c4);
		case (p)
			3'h0:    ctrl_of = c0;
			3'h1:    ctrl_of = c1;
			3'h2:    ctrl_of = c2;
			3'h3:    ctrl_of = c3;
			3'h4:    ctrl_of = c4;
			default: ctrl_of = CTRL_RESET;
		endcase
	endfunction : ctrl_of

	assign sel  = port_of_addr(reg_addr_in);
	assign ictl = ctrl_of(ingress_port_in, ctrl[0], ctrl[1], ctrl[2], ctrl[3], ctrl[4]);
	assign ectl = ctrl_of(egress_port_in, ctrl[0], ctrl[1], ctrl[2], ctrl[3], ctrl[4]);

	// per-port byte, zero at reset, written in place
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				ctrl[i] <= CTRL_RESET;
			end
		end else if (ref_clk_en_in && reg_wr_en_in && sel != NO_PORT) begin
			ctrl[sel] <= reg_wdata_in;
		end
	end

	// register readback, unmapped reads as zero
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (ref_clk_en_in && reg_rd_en_in) begin
			reg_rdata_out <= ctrl_of(sel, ctrl[0], ctrl[1], ctrl[2], ctrl[3], ctrl[4]);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			storm_protect_en_out <= '0;
		end else if (ref_clk_en_in) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				storm_protect_en_out[i] <= ctrl[i][STORM_EN_BIT];
			end
		end
	end

	assign use_dscp = ictl[DSCP_EN_BIT] && dscp_valid_in;
	assign use_pcp  = ictl[PCP_EN_BIT] && pcp_valid_in;

	always_comb begin
		next_prio = ictl[PORT_PRIO_HI:PORT_PRIO_LO];
		if (use_dscp || use_pcp) begin
			next_prio = (use_dscp ? dscp_prio_in : 2'h0) | (use_pcp ? pcp_prio_in : 2'h0);
		end
	end

	assign split_code = {split_hi_in[ingress_port_in < 3'h5 ? ingress_port_in : 3'h0],
			ictl[SPLIT_LO_BIT]};

	always_comb begin
		case (split_code)
			SPLIT_FOUR: next_queue = next_prio;
			SPLIT_TWO:  next_queue = {1'h0, next_prio[1]};
			default:    next_queue = 2'h0;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			class_valid_out <= 1'h0;
			class_prio_out  <= 2'h0;
			class_queue_out <= 2'h0;
		end else if (ref_clk_en_in) begin
			class_valid_out <= ingress_valid_in;
			if (ingress_valid_in) begin
				class_prio_out  <= next_prio;
				class_queue_out <= next_queue;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			egress_valid_out     <= 1'h0;
			egress_add_tag_out   <= 1'h0;
			egress_strip_tag_out <= 1'h0;
			egress_vid_out       <= '0;
		end else if (ref_clk_en_in) begin
			egress_valid_out <= egress_valid_in;
			if (egress_valid_in) begin
				egress_add_tag_out   <= ectl[TAG_INSERT_BIT] && !egress_arrived_tagged_in;
				egress_strip_tag_out <= ectl[TAG_REMOVE_BIT] && egress_arrived_tagged_in;
				if (egress_src_port_in < 3'h5) begin
					egress_vid_out <= port_default_vlan_id_in[egress_src_port_in*VID_W +: VID_W];
				end else begin
					egress_vid_out <= '0;
				end
			end
		end
	end

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_ing_take;
		ref_clk_en_in && ingress_valid_in;
	endsequence

	sequence s_egr_take;
		ref_clk_en_in && egress_valid_in;
	endsequence

	a_write_readback: assert property (
		ref_clk_en_in && reg_wr_en_in && sel != NO_PORT ##1
		ref_clk_en_in && reg_rd_en_in && !reg_wr_en_in && sel == $past(sel)
		|=> reg_rdata_out == $past(reg_wdata_in, 2))
		else $error("readback differs from written byte");

	a_storm_follow: assert property (
		ref_clk_en_in |=> storm_protect_en_out[0] == $past(ctrl[0][STORM_EN_BIT]))
		else $error("storm enable not following control bit");

	a_port_prio_default: assert property (
		s_ing_take ##0 !use_dscp && !use_pcp
		|=> class_prio_out == $past(ictl[PORT_PRIO_HI:PORT_PRIO_LO]))
		else $error("port priority not used");

	a_or_override: assert property (
		s_ing_take ##0 use_dscp && use_pcp
		|=> class_prio_out == ($past(dscp_prio_in) | $past(pcp_prio_in)))
		else $error("classifier results not combined");

	a_dscp_off: assert property (
		s_ing_take ##0 !ictl[DSCP_EN_BIT] && !use_pcp
		|=> class_prio_out == $past(ictl[PORT_PRIO_HI:PORT_PRIO_LO]))
		else $error("dscp used while disabled");

	a_insert_untagged: assert property (
		s_egr_take |=> egress_add_tag_out ==
		($past(ectl[TAG_INSERT_BIT]) && !$past(egress_arrived_tagged_in)))
		else $error("tag insertion wrong");

	a_strip_tagged: assert property (
		s_egr_take ##0 !egress_arrived_tagged_in |=> !egress_strip_tag_out)
		else $error("untagged packet stripped");

	a_single_queue: assert property (
		s_ing_take ##0 split_code == SPLIT_SINGLE |=> class_queue_out == 2'h0)
		else $error("single queue setting not honoured");

	a_four_queue: assert property (
		s_ing_take ##0 split_code == SPLIT_FOUR |=> class_queue_out == class_prio_out)
		else $error("four queue mapping wrong");

	a_reset_zero: assert property (
		@(posedge ref_clk_in) disable iff (1'h0)
		sys_rst_in |=> ctrl[4] == CTRL_RESET && reg_rdata_out == 8'h00)
		else $error("control byte not cleared by reset");

endmodule : port_ingress_priority_tag_control
`default_nettype wire

// ---- bench/port_ingress_priority_tag_control_test.sv ----
`timescale 1ns/1ns
`default_nettype none

module port_ingress_priority_tag_control_test
	import port_ctrl_pkg::*;
;

	localparam logic [NUM_PORTS*VID_W-1:0] VIDS = {12'h5a5, 12'h4b4, 12'h3c3, 12'h2d2, 12'h1e1};

	logic                  clk = 1'h0;
	logic                  rst = 1'h1;
	logic                  ce = 1'h1;
	logic                  wr = 1'h0;
	logic                  rd = 1'h0;
	logic [ADDR_W-1:0]     addr = 8'h00;
	logic [DATA_W-1:0]     wdata = 8'h00;
	logic [NUM_PORTS-1:0]  sp = 5'h00;
	logic                  iv = 1'h0;
	logic [2:0]            ip = 3'h0;
	logic                  dv = 1'h0;
	logic [1:0]            dp = 2'h0;
	logic                  pv = 1'h0;
	logic [1:0]            pp = 2'h0;
	logic                  ev = 1'h0;
	logic [2:0]            ep = 3'h0;
	logic [2:0]            es = 3'h0;
	logic                  et = 1'h0;
	logic [DATA_W-1:0]     rdata;
	logic [NUM_PORTS-1:0]  storm;
	logic                  cv;
	logic [1:0]            cp;
	logic [1:0]            cq;
	logic                  eo;
	logic                  add;
	logic                  strip;
	logic [VID_W-1:0]      vid;
	logic [7:0]            sh [NUM_PORTS];
	int                    bad_count = 0;
	int                    tests_run = 0;

	always #50 clk = ~clk;

	port_ingress_priority_tag_control uut (
		.ref_clk_in(clk), .sys_rst_in(rst), .ref_clk_en_in(ce),
		.reg_wr_en_in(wr), .reg_rd_en_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.split_hi_in(sp), .port_default_vlan_id_in(VIDS), .ingress_valid_in(iv),
		.ingress_port_in(ip), .dscp_valid_in(dv), .dscp_prio_in(dp), .pcp_valid_in(pv),
		.pcp_prio_in(pp), .egress_valid_in(ev), .egress_port_in(ep),
		.egress_src_port_in(es), .egress_arrived_tagged_in(et), .reg_rdata_out(rdata),
		.storm_protect_en_out(storm), .class_valid_out(cv), .class_prio_out(cp),
		.class_queue_out(cq), .egress_valid_out(eo), .egress_add_tag_out(add),
		.egress_strip_tag_out(strip), .egress_vid_out(vid));

	task automatic end_of_test;
		if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'h0;
		if (ce && a[3:0] == 4'h0 && a[7:4] >= 4'h1 && a[7:4] <= 4'h5) sh[a[7:4]-1] = d;
	endtask : wr_reg

	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'h0;
		rd <= 1'h1;
		sh[a[7:4]-1] = d;
		@(posedge clk);
		rd <= 1'h0;
		#10 chk(rdata, d);
	endtask : wr_rd

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#10 chk(rdata, e);
	endtask : rd_reg

	task automatic ing(input int p, input logic d, input logic u,
			input logic [1:0] dq, input logic [1:0] uq);
		logic       use_c;
		logic [1:0] e;
		logic [1:0] sc;
		logic [1:0] q;
		use_c = (sh[p][6] & d) | (sh[p][5] & u);
		e = use_c ? (((sh[p][6] & d) ? dq : 2'h0) | ((sh[p][5] & u) ? uq : 2'h0)) : sh[p][4:3];
		sc = {sp[p], sh[p][0]};
		q = (sc == 2'h2) ? e : (sc == 2'h1) ? {1'h0, e[1]} : 2'h0;
		@(posedge clk);
		iv <= 1'h1;
		ip <= p[2:0];
		dv <= d;
		pv <= u;
		dp <= dq;
		pp <= uq;
		@(posedge clk);
		iv <= 1'h0;
		#10 chk(cv, 1'h1);
		chk(cp, e);
		chk(cq, q);
	endtask : ing

	task automatic egr(input int p, input int s, input logic t);
		@(posedge clk);
		ev <= 1'h1;
		ep <= p[2:0];
		es <= s[2:0];
		et <= t;
		@(posedge clk);
		ev <= 1'h0;
		#10 chk(eo, 1'h1);
		chk(add, sh[p][2] & ~t);
		chk(strip, sh[p][1] & t);
		if (sh[p][2] & ~t) chk(vid, VIDS[VID_W*s +: VID_W]);
	endtask : egr

	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		end_of_test();
	end

	initial begin
		for (int i = 0; i < NUM_PORTS; i++) sh[i] = 8'h00;
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		for (int i = 1; i <= 5; i++) rd_reg(8'(i * 16), 8'h00);
		chk(storm, 5'h00);
		for (int i = 1; i <= 5; i++) wr_reg(8'(i * 16), 8'(8'h31 * i + (i[0] ? 8'h80 : 8'h00)));
		for (int i = 1; i <= 5; i++) rd_reg(8'(i * 16), sh[i-1]);
		#10 chk(storm, {sh[4][7], sh[3][7], sh[2][7], sh[1][7], sh[0][7]});
		wr_reg(8'h11, 8'hff);
		rd_reg(8'h11, 8'h00);
		rd_reg(8'h10, sh[0]);
		@(posedge clk);
		ce <= 1'h0;
		wr_reg(8'h20, 8'hee);
		@(posedge clk);
		ce <= 1'h1;
		rd_reg(8'h20, sh[1]);
		wr_rd(8'h30, 8'h5c);
		for (int i = 0; i < 32; i++) begin
			@(posedge clk);
			sp <= {5{i[2]}};
			wr_reg(8'((i % 5 + 1) * 16), {1'h0, i[0], i[1], i[3:2], 2'h0, i[4]});
			for (int j = 0; j < 4; j++) ing(i % 5, j[0], j[1], 2'(j + 1), 2'(~j));
		end
		for (int k = 0; k < 20; k++) begin
			wr_reg(8'((k % 5 + 1) * 16), {5'h00, k[1], k[2], 1'h0});
			egr(k % 5, (k + 2) % 5, k[0]);
		end
		end_of_test();
	end
endmodule : port_ingress_priority_tag_control_test

`default_nettype wire
